/* File: iau_pkg.sv */
// shared constants, carriers and states of the interrupt acknowledge unit
package iau_pkg;
  // ----------------------------------------
  // register map (byte offsets, word aligned)
  // ----------------------------------------
  localparam logic [7:0] OFS_SAMPLE_SEL = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_URG = 8'h10;
  localparam logic [7:0] OFS_PSW = 8'h14;
  localparam logic [7:0] OFS_PSW_SET = 8'h18;
  localparam logic [7:0] OFS_PSW_CLR = 8'h1C;
  localparam logic [7:0] OFS_DIV = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_SAMPLE_SEL = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_URG = 8'hFF;
  localparam logic [7:0] RST_PSW = 8'h02;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;
  localparam int EDGE_LO_BIT = 2;
  localparam int EDGE_HI_BIT = 3;
  localparam logic [1:0] SMP_CPU = 2'h0;
  localparam logic [1:0] SMP_DIV6 = 2'h1;
  localparam int PER_DIV_A = 6;
  localparam int PER_DIV_B = 7;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int NSRC = 8;
  localparam logic [3:0] VEC_NMI = 4'h8;
  localparam logic [3:0] VEC_TRAP = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------
  // carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic instr_done;
    logic halt;
    logic acceptance_on_op;
    logic acceptance_off_op;
    logic service_return_op;
    logic break_return_op;
    logic software_trap_op;
    logic psw_push_op;
    logic psw_pop_op;
    logic [7:0] pop_data;
  } iau_cpu_in_t;
  typedef struct packed {
    logic push_psw;
    logic push_pc;
    logic load_vector;
    logic [3:0] vector_id;
    logic [7:0] psw_data;
  } iau_cpu_out_t;
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH_PSW, ST_PUSH_PC, ST_WAIT, ST_LOAD} iau_state_t;
endpackage

/* File: iau_noise_filter.sv */
// noise eliminator and valid edge detector for external line zero
module iau_noise_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_tick,
  input wire logic ext_line_zero,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse_q
);
  import iau_pkg::*;
  logic smp_q;
  logic lvl_q;
  logic lvl_ok_q;
  logic agree;
  logic rise;
  logic fall;

  // a level counts only when two successive samples agree
  assign agree = sample_tick && (ext_line_zero == smp_q);
  assign rise = agree && lvl_ok_q && !lvl_q && ext_line_zero;
  assign fall = agree && lvl_ok_q && lvl_q && !ext_line_zero;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_q <= 1'b0;
      lvl_q <= 1'b0;
      lvl_ok_q <= 1'b0;
    end else if (sample_tick) begin
      smp_q <= ext_line_zero;
      if (agree) begin
        lvl_q <= ext_line_zero;
        lvl_ok_q <= 1'b1;
      end
    end
  end

  // the prohibited code 10 selects no edge at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_pulse_q <= 1'b0;
    end else begin
      case (edge_sel)
        EDGE_FALL: edge_pulse_q <= fall;
        EDGE_RISE: edge_pulse_q <= rise;
        EDGE_BOTH: edge_pulse_q <= rise || fall;
        default: edge_pulse_q <= 1'b0;
      endcase
    end
  end

  a_edge_two_samples: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_pulse_q |-> $past(sample_tick) && ($past(ext_line_zero) == $past(smp_q)))
    else $error("edge flagged without two agreeing samples");
endmodule

/* File: iau_arbiter.sv */
// picks the maskable source to acknowledge next
module iau_arbiter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [iau_pkg::NSRC-1:0] flags,
  input wire logic [iau_pkg::NSRC-1:0] mask,
  input wire logic [iau_pkg::NSRC-1:0] urg,
  input wire logic service_level_bit,
  output logic valid_q,
  output logic [2:0] index_q,
  output logic low_q
);
  import iau_pkg::*;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] hi_set;

  // lowest index wins: the fixed ranking, used only to break ties
  function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
    first_set = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) first_set = i[2:0];
    end
  endfunction

  // low urgency sources drop out while a high urgency one is in service
  assign elig = flags & ~mask & (service_level_bit ? {NSRC{1'b1}} : ~urg);
  assign hi_set = elig & ~urg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_q <= 1'b0;
      index_q <= 3'h0;
      low_q <= 1'b1;
    end else begin
      valid_q <= |elig;
      low_q <= ~|hi_set;
      index_q <= |hi_set ? first_set(hi_set) : first_set(elig);
    end
  end
endmodule

/* File: iau_top.sv */
// interrupt acknowledge unit: registers, state word and acknowledge sequencer
// ----------------------------------------
// Overview of operation
// - line zero sampled by selected sample clock
// - sample select register resets to zero
// - request only after two agreeing active samples
// - pulse between samples leaves flag clear
// - choices: cpu clock, oscillator over 64, 128
// - vector or trap pushes state word, clears enable
// - maskable acknowledge copies urgency into service level
// - state word resets to 02h
// - returns and pop restore, push saves state word
// - byte, bit and on/off ops on state word
// - non-maskable ignores enable and outranks all
// - non-maskable pushes word, pc, clears both bits
// - nested non-maskable waits return plus one instruction
// - several nested non-maskable give one acknowledge
// - maskable needs flag, no block, enable set
// - high service level blocks low urgency requests
// - latency 7 to 32, low urgency one more
// - urgency first, then fixed ranking among ties
// - pending requests stay latched until allowed
// - maskable pushes word, pc, loads own vector
// - acknowledge clears the source request flag
// - block and urgency bits reset to ones
// - edge codes: fall, rise, both; 10 prohibited
// ----------------------------------------
module iau_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_line_zero,
  input wire logic [iau_pkg::NSRC-1:1] src_req,
  input wire logic nmi_req,
  input wire iau_pkg::iau_cpu_in_t cpu_in,
  output iau_pkg::iau_cpu_out_t cpu_out
);
  import iau_pkg::*;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic aw_have_q, w_have_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic w_lane_q;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic rd_hit;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:6] == 26'h0) && (a[1:0] == 2'h0) && (a[7:0] <= OFS_STATUS);
  endfunction

  function automatic logic wr_at(input logic fire, input logic lane, input logic [31:0] a,
                                 input logic [7:0] ofs);
    wr_at = fire && lane && mapped(a) && (a[7:0] == ofs);
  endfunction

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 32'h0;
      w_data_q <= 32'h0;
      w_lane_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_lane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // clock dividers
  // ----------------------------------------
  // aclk stands for the main oscillator; every divided clock is an enable
  logic [6:0] pre_q;
  logic [2:0] div_q;
  logic [7:0] sample_sel_q;
  logic cpu_tick, sample_tick;

  function automatic logic div_tick(input logic [6:0] cnt, input int k);
    div_tick = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < k && !cnt[i]) div_tick = 1'b0;
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) pre_q <= 7'h0;
    else pre_q <= pre_q + 7'h1;
  end

  // the cpu clock stops in halt, the peripheral clocks keep running
  assign cpu_tick = div_tick(pre_q, 32'(div_q) + 1) && !cpu_in.halt;
  always_comb begin
    case (sample_sel_q[1:0])
      SMP_CPU: sample_tick = cpu_tick;
      SMP_DIV6: sample_tick = div_tick(pre_q, PER_DIV_A);
      default: sample_tick = div_tick(pre_q, PER_DIV_B);
    endcase
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] edge_q, mask_q, urg_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_sel_q <= RST_SAMPLE_SEL;
      edge_q <= RST_EDGE;
      mask_q <= RST_MASK;
      urg_q <= RST_URG;
      div_q <= RST_DIV;
    end else begin
      if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_SAMPLE_SEL)) sample_sel_q <= w_data_q[7:0];
      if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_EDGE)) edge_q <= w_data_q[7:0];
      if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_MASK)) mask_q <= w_data_q[7:0];
      if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_URG)) urg_q <= w_data_q[7:0];
      // divider values above four are clamped to the slowest cpu clock
      if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_DIV)) begin
        div_q <= (w_data_q[2:0] > DIV_MAX) ? DIV_MAX : w_data_q[2:0];
      end
    end
  end

  // ----------------------------------------
  // request flags
  // ----------------------------------------
  logic line_zero_edge;
  logic [7:0] flag_q, flag_set, flag_clr;
  logic arb_valid, arb_low;
  logic [2:0] arb_index;
  logic [7:0] psw_q;
  iau_state_t state_q;
  logic take_nmi, take_mask, take_trap;

  iau_noise_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_tick(sample_tick),
    .ext_line_zero(ext_line_zero),
    .edge_sel(edge_q[EDGE_HI_BIT:EDGE_LO_BIT]),
    .edge_pulse_q(line_zero_edge)
  );

  assign flag_set = {src_req, line_zero_edge};
  assign flag_clr = take_mask ? (8'h01 << arb_index) : 8'h00;

  // a new request beats both the acknowledge clear and a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_q <= RST_FLAG;
    else if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_FLAG)) flag_q <= w_data_q[7:0] | flag_set;
    else flag_q <= (flag_q & ~flag_clr) | flag_set;
  end

  iau_arbiter u_arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .flags(flag_q & ~flag_clr),
    .mask(mask_q),
    .urg(urg_q),
    .service_level_bit(psw_q[PSW_ISP_BIT]),
    .valid_q(arb_valid),
    .index_q(arb_index),
    .low_q(arb_low)
  );

  // ----------------------------------------
  // non-maskable tracking and hold
  // ----------------------------------------
  logic nmi_pend_q, nmi_active_q, hold_q, hold_op;

  // these ops defer any acknowledge until one more instruction completes
  assign hold_op = cpu_in.service_return_op || cpu_in.break_return_op
                || cpu_in.acceptance_on_op || cpu_in.acceptance_off_op
                || cpu_in.psw_push_op || cpu_in.psw_pop_op;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pend_q <= 1'b0;
      nmi_active_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      // one latch, so any number of nested requests leaves one behind
      if (nmi_req) nmi_pend_q <= 1'b1;
      else if (take_nmi) nmi_pend_q <= 1'b0;
      if (take_nmi) nmi_active_q <= 1'b1;
      else if (cpu_in.service_return_op) nmi_active_q <= 1'b0;
      if (hold_op) hold_q <= 1'b1;
      else if (cpu_in.instr_done) hold_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // acknowledge sequencer
  // ----------------------------------------
  logic boundary;
  logic kind_nmi_q, kind_mask_q, low_q;
  logic [3:0] vec_q;

  // a hold op rides on its own instr_done, so the next completed instruction
  // is the boundary; hold_q stays only as a status bit
  assign boundary = (state_q == ST_IDLE) && cpu_in.instr_done && !hold_op;
  assign take_nmi = boundary && nmi_pend_q && !nmi_active_q;
  // the arbiter result is a cycle old, so it is rechecked against the live registers;
  // a trap clears the enable flag, so a maskable request waits behind it
  assign take_mask = boundary && !take_nmi && !nmi_active_q && arb_valid
                  && psw_q[PSW_IE_BIT] && flag_q[arb_index] && !mask_q[arb_index]
                  && (psw_q[PSW_ISP_BIT] || !urg_q[arb_index])
                  && !cpu_in.software_trap_op;
  assign take_trap = (state_q == ST_IDLE) && cpu_in.software_trap_op && !take_nmi;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      kind_nmi_q <= 1'b0;
      kind_mask_q <= 1'b0;
      low_q <= 1'b0;
      vec_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take_nmi || take_mask || take_trap) state_q <= ST_PUSH_PSW;
          kind_nmi_q <= take_nmi;
          kind_mask_q <= take_mask;
          low_q <= take_mask && arb_low;
          if (take_nmi || take_mask || take_trap) begin
            vec_q <= take_nmi ? VEC_NMI : (take_mask ? {1'b0, arb_index} : VEC_TRAP);
          end
        end
        ST_PUSH_PSW: if (cpu_tick) state_q <= ST_PUSH_PC;
        ST_PUSH_PC: if (cpu_tick) state_q <= ST_WAIT;
        // low urgency sources spend one extra cpu cycle here
        ST_WAIT: begin
          if (cpu_tick && low_q) low_q <= 1'b0;
          else if (cpu_tick) state_q <= ST_LOAD;
        end
        ST_LOAD: if (cpu_tick) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // the trap has no program counter push of its own here: the sequencer
  // still emits it so the core pushes its return address the same way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_out <= '0;
    end else begin
      cpu_out.push_psw <= (state_q == ST_PUSH_PSW) && cpu_tick;
      cpu_out.push_pc <= (state_q == ST_PUSH_PC) && cpu_tick;
      cpu_out.load_vector <= (state_q == ST_LOAD) && cpu_tick;
      cpu_out.vector_id <= vec_q;
      cpu_out.psw_data <= psw_q;
    end
  end

  // ----------------------------------------
  // program state word
  // ----------------------------------------
  logic save_step;
  assign save_step = (state_q == ST_PUSH_PSW) && cpu_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psw_q <= RST_PSW;
    end else if (save_step) begin
      psw_q[PSW_IE_BIT] <= 1'b0;
      if (kind_nmi_q) psw_q[PSW_ISP_BIT] <= 1'b0;
      else if (kind_mask_q) psw_q[PSW_ISP_BIT] <= urg_q[vec_q[2:0]];
    end else if (cpu_in.psw_pop_op || cpu_in.service_return_op || cpu_in.break_return_op) begin
      psw_q <= cpu_in.pop_data;
    end else if (cpu_in.acceptance_on_op) begin
      psw_q[PSW_IE_BIT] <= 1'b1;
    end else if (cpu_in.acceptance_off_op) begin
      psw_q[PSW_IE_BIT] <= 1'b0;
    end else if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_PSW)) begin
      psw_q <= w_data_q[7:0];
    end else if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_PSW_SET)) begin
      psw_q <= psw_q | w_data_q[7:0];
    end else if (wr_at(wr_fire, w_lane_q, aw_addr_q, OFS_PSW_CLR)) begin
      psw_q <= psw_q & ~w_data_q[7:0];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    rd_hit = mapped(s_axi_araddr);
    case (s_axi_araddr[7:0])
      OFS_SAMPLE_SEL: rd_mux = {24'h0, sample_sel_q};
      OFS_EDGE: rd_mux = {24'h0, edge_q};
      OFS_FLAG: rd_mux = {24'h0, flag_q};
      OFS_MASK: rd_mux = {24'h0, mask_q};
      OFS_URG: rd_mux = {24'h0, urg_q};
      OFS_PSW: rd_mux = {24'h0, psw_q};
      OFS_DIV: rd_mux = {29'h0, div_q};
      OFS_STATUS: rd_mux = {20'h0, vec_q, nmi_active_q, nmi_pend_q, hold_q, 1'b0,
                            (state_q != ST_IDLE), 3'h0};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_mux : 32'h0;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_psw_then_pc;
    cpu_out.push_psw ##[1:300] cpu_out.push_pc;
  endsequence

  a_push_order: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cpu_out.push_psw) |-> s_psw_then_pc)
    else $error("pc push did not follow state word push");
  a_ie_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    save_step |=> !psw_q[PSW_IE_BIT])
    else $error("enable flag survived acknowledge");
  a_isp_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    save_step && kind_mask_q |=> psw_q[PSW_ISP_BIT] == $past(urg_q[vec_q[2:0]]))
    else $error("service level not copied from urgency");
  a_nmi_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    save_step && kind_nmi_q |=> psw_q[PSW_ISP_BIT] == 1'b0 && psw_q[PSW_IE_BIT] == 1'b0)
    else $error("non-maskable acknowledge left state bits set");
  a_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    take_mask |-> psw_q[PSW_IE_BIT] && !mask_q[arb_index])
    else $error("maskable taken while blocked or disabled");
  a_low_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    take_mask && urg_q[arb_index] |-> psw_q[PSW_ISP_BIT])
    else $error("low urgency taken during high urgency service");
  a_nmi_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_in.service_return_op |=> !take_nmi)
    else $error("non-maskable taken right after return");
  a_flag_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    take_mask && !flag_set[arb_index] |=> !flag_q[$past(arb_index)])
    else $error("request flag not cleared on acknowledge");
  a_enable_ops: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_in.acceptance_on_op && state_q == ST_IDLE && !take_trap && !cpu_in.psw_pop_op
    && !cpu_in.service_return_op && !cpu_in.break_return_op |=> psw_q[PSW_IE_BIT])
    else $error("acceptance-on did not set enable");
endmodule

/* File: iau_cpu_model.sv */
// cpu core model: instruction pacing, state word stack and service returns
module iau_cpu_model
  import iau_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ret_req,
  input wire logic ei_req,
  input wire logic trap_req,
  input wire iau_pkg::iau_cpu_out_t cpu_out,
  output iau_pkg::iau_cpu_in_t cpu_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  logic [1:0] sp_q;
  logic busy_q;
  logic ret_q;
  logic ei_q, trap_q, brk_q;
  logic [7:0] stk_q [4];
  // ----
  // one instruction every four cycles, none while a vector is being taken
  // ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
      sp_q <= 2'h0;
      busy_q <= 1'b0;
      ret_q <= 1'b0;
      ei_q <= 1'b0;
      trap_q <= 1'b0;
      brk_q <= 1'b0;
      cpu_in <= '0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      cpu_in <= '0;
      if (ret_req) ret_q <= 1'b1;
      if (ei_req) ei_q <= 1'b1;
      if (trap_req) trap_q <= 1'b1;
      if (cpu_out.push_psw) begin
        stk_q[sp_q] <= cpu_out.psw_data;
        sp_q <= sp_q + 2'h1;
        busy_q <= 1'b1;
      end
      if (cpu_out.load_vector) busy_q <= 1'b0;
      if (cnt_q == 2'h3 && !busy_q && !cpu_out.push_psw) begin
        cpu_in.instr_done <= 1'b1;
        // the handler leaves through a return, service or break, popping its word
        if (ret_q) begin
          // a trap handler leaves through the break return instead
          cpu_in.service_return_op <= !brk_q;
          cpu_in.break_return_op <= brk_q;
          cpu_in.pop_data <= stk_q[sp_q - 2'h1];
          sp_q <= sp_q - 2'h1;
          ret_q <= 1'b0;
          brk_q <= 1'b0;
        end else if (trap_q) begin
          cpu_in.software_trap_op <= 1'b1;
          trap_q <= 1'b0;
          brk_q <= 1'b1;
        end else if (ei_q) begin
          cpu_in.acceptance_on_op <= 1'b1;
          ei_q <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: iau_top_tb_top.sv */
// self-checking bench of the interrupt acknowledge unit
module iau_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import iau_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, ext_line_zero = 1'b0, nmi_req = 1'b0, ret_req = 1'b0;
  logic ei_req = 1'b0, trap_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp, bres;
  logic [7:1] src_req = '0;
  logic [3:0] last_vec = 4'h0;
  logic [3:0] ord [3] = '{4'h3, 4'h2, 4'h6};
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h02};
  iau_cpu_in_t cpu_in;
  iau_cpu_out_t cpu_out;
  int num_errors = 0, num_checks = 0, n_ack = 0, exp_ack = 0, tmo = 0, n_pc = 0;
  time t0;
  iau_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_line_zero, .src_req, .nmi_req, .cpu_in, .cpu_out);
  iau_cpu_model u_cpu (.aclk, .aresetn, .ret_req, .ei_req, .trap_req, .cpu_out, .cpu_in);
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (cpu_out.load_vector === 1'b1) begin
      n_ack <= n_ack + 1;
      last_vec <= cpu_out.vector_id;
    end
    if (cpu_out.push_pc === 1'b1) n_pc <= n_pc + 1;
  end
  // ----
  // bus and sequencing tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta;
    logic td;
    ta = 1'b0;
    td = 1'b0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && td)) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      td = td | s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !td;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    bres = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, rdat, rresp);
    chk($sformatf("register %h", a), {24'h0, e}, rdat);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // counting expected acknowledges avoids missing one that lands during a bus call
  task automatic vchk(input logic [3:0] v);
    exp_ack++;
    while (n_ack < exp_ack) @(posedge aclk);
    chk("vector", {28'h0, v}, {28'h0, last_vec});
  endtask
  task automatic quiet(input int n);
    cyc(n);
    chk("acknowledges", 32'(exp_ack), 32'(n_ack));
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge aclk);
    ret_req <= 1'b0;
  endtask
  task automatic ei();
    ei_req <= 1'b1;
    @(posedge aclk);
    ei_req <= 1'b0;
  endtask
  task automatic trap();
    trap_req <= 1'b1;
    @(posedge aclk);
    trap_req <= 1'b0;
  endtask
  task automatic pulse(input logic [7:1] s);
    src_req <= s;
    @(posedge aclk);
    src_req <= '0;
  endtask
  task automatic npulse();
    nmi_req <= 1'b1;
    @(posedge aclk);
    nmi_req <= 1'b0;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge aclk) begin
    tmo++;
    if (tmo == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ofs[i]) rchk(ofs[i], rv[i]);
    rd(8'h28, rdat, rresp);
    chk("rresp", 32'h3, {30'h0, rresp});
    wr(8'h28, 8'h00);
    chk("bresp", 32'h3, {30'h0, bres});
    pulse(7'h04);
    quiet(40);
    rchk(OFS_FLAG, 8'h08);
    wr(OFS_MASK, 8'hF7);
    wr(OFS_URG, 8'hF7);
    quiet(40);
    wr(OFS_PSW_SET, 8'h80);
    vchk(4'h3);
    rchk(OFS_PSW, 8'h00);
    rchk(OFS_FLAG, 8'h00);
    ret();
    cyc(20);
    rchk(OFS_PSW, 8'h82);
    trap();
    vchk(4'h9);
    rchk(OFS_PSW, 8'h02);
    ret();
    cyc(20);
    rchk(OFS_PSW, 8'h82);
    t0 = $time;
    pulse(7'h04);
    vchk(4'h3);
    chk("latency", 32'h1, {31'h0, ($time - t0) <= 64 * 50});
    wr(OFS_MASK, 8'hD7);
    ei();
    pulse(7'h10);
    quiet(60);
    ret();
    vchk(4'h5);
    ret();
    cyc(20);
    wr(OFS_PSW_CLR, 8'h80);
    wr(OFS_MASK, 8'h00);
    pulse(7'h26);
    wr(OFS_PSW_SET, 8'h80);
    foreach (ord[i]) begin
      vchk(ord[i]);
      ret();
    end
    cyc(20);
    wr(OFS_PSW_CLR, 8'h80);
    npulse();
    vchk(4'h8);
    rchk(OFS_PSW, 8'h00);
    npulse();
    cyc(3);
    npulse();
    quiet(40);
    ret();
    vchk(4'h8);
    ret();
    quiet(60);
    rchk(OFS_PSW, 8'h02);
    wr(OFS_SAMPLE_SEL, 8'h01);
    wr(OFS_EDGE, 8'h04);
    cyc(300);
    ext_line_zero <= 1'b1;
    @(posedge aclk);
    ext_line_zero <= 1'b0;
    cyc(300);
    rchk(OFS_FLAG, 8'h00);
    ext_line_zero <= 1'b1;
    cyc(300);
    rchk(OFS_FLAG, 8'h01);
    wr(OFS_FLAG, 8'h00);
    wr(OFS_EDGE, 8'h00);
    ext_line_zero <= 1'b0;
    cyc(300);
    rchk(OFS_FLAG, 8'h01);
    wr(OFS_FLAG, 8'h00);
    wr(OFS_SAMPLE_SEL, 8'h02);
    wr(OFS_EDGE, 8'h08);
    ext_line_zero <= 1'b1;
    cyc(300);
    rchk(OFS_FLAG, 8'h00);
    wr(OFS_EDGE, 8'h0C);
    ext_line_zero <= 1'b0;
    cyc(300);
    rchk(OFS_FLAG, 8'h01);
    wr(OFS_DIV, 8'h07);
    rchk(OFS_DIV, 8'h04);
    chk("pc pushes", 32'(n_ack), 32'(n_pc));
    finish_test();
  end
endmodule
